/* dkhs_defs.svh */
`ifndef DKHS_DEFS_SVH
`define DKHS_DEFS_SVH

// =========================================================================
// Timing constants
// =========================================================================
// System clock period in nanoseconds.
`define DKHS_CLK_NS        20
// Command complete drop and attention lead time in nanoseconds.
`define DKHS_T100_NS       100
// Lead cycles, rounded up.
`define DKHS_LEAD_CYC      ((`DKHS_T100_NS + `DKHS_CLK_NS - 1) / `DKHS_CLK_NS)
// Idle and handshake limit in milliseconds.
`define DKHS_T10_MS        10
// Cycles in 10 ms, rounded down.
`define DKHS_IDLE_CYC      ((`DKHS_T10_MS * 1000000) / `DKHS_CLK_NS)
// Bit times allowed for address mark found.
`define DKHS_AMF_BITS      8
// Minimum reference clock half period in system cycles.
`define DKHS_REF_HALF      2
// Optical stretch limit in minimum periods.
`define DKHS_OPT_MAX       15
// Number of status bits that may raise attention (bits 9..0); the core masks them, so none does.
`define DKHS_ATTN_BITS     10

`endif

/* dkhs_pkg.sv */
package dkhs_pkg;
    // Handshake sequencer states.
    typedef enum logic [2:0] {
        DKHS_IDLE,
        DKHS_XFER,
        DKHS_EXEC,
        DKHS_LEAD,
        DKHS_ERRWAIT,
        DKHS_DONE
    } dkhs_state_t;
endpackage

/* dkhs_fifo.sv */
`timescale 1ns/1ps
// =========================================================================
// Small FIFO for captured write data
// =========================================================================
module dkhs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    // Depth must be a power of two for the wrapping pointers.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("dkhs_fifo depth must be a power of two");
    end

    // Both pointers in one packed struct.
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } dkhs_fifo_st_t;

    logic [WIDTH-1:0] mem [DEPTH];    // Storage array.
    dkhs_fifo_st_t    st_reg;         // Pointer state.
    dkhs_fifo_st_t    st_next;        // Next pointer state.
    logic             push;           // Write accepted.
    logic             pop;            // Read accepted.

    assign in_ready  = (st_reg.wr - st_reg.rd) != (AW+1)'(DEPTH);
    assign out_valid = st_reg.wr != st_reg.rd;
    assign out_data  = mem[st_reg.rd[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer update.
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wr = st_reg.wr + 1'b1;
        end
        if (pop) begin
            st_next.rd = st_reg.rd + 1'b1;
        end
    end

    // Registers, synchronous reset.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
        if (push) begin
            mem[st_reg.wr[AW-1:0]] <= in_data;
        end
    end
endmodule // dkhs_fifo

/* dkhs_core.sv */
`timescale 1ns/1ps
`include "dkhs_defs.svh"
// =========================================================================
// Drive-side handshake and timing core
// =========================================================================
// Control pins are active low at the connector; the core takes and gives
// asserted-high levels and the pad logic inverts.
module dkhs_core #(
    parameter int IDLE_CYC  = `DKHS_IDLE_CYC,
    parameter int REF_HALF  = `DKHS_REF_HALF,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        xfer_req,
    input  wire logic        cmd_bit,
    output logic             xfer_ack,
    output logic             stat_bit,
    output logic             cmd_cmpl,
    output logic             attn,
    input  wire logic        write_gate,
    input  wire logic        am_enable,
    input  wire logic        write_clk,
    input  wire logic        write_data,
    input  wire logic        read_am_seen,
    output logic             am_found,
    output logic             ref_clk,
    output logic             sync_start,
    output logic             write_am,
    output logic             cmd_valid,
    output logic [15:0]      cmd_word,
    output logic             cmd_fault,
    input  wire logic        exec_done,
    input  wire logic        exec_error,
    input  wire logic        status_req,
    input  wire logic [15:0] status_word,
    output logic [7:0]       wr_byte,
    output logic             wr_byte_valid,
    input  wire logic        wr_byte_ready,
    output logic             xfer_fault
);
    // Elaboration check: the half-period counter is eight bits wide.
    if (IDLE_CYC < 1 || REF_HALF < 1 || REF_HALF > 256) begin : g_bad_param
        $error("dkhs_core timing parameters out of range");
    end

    localparam int ICW = $clog2(IDLE_CYC + 1);

    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        logic [1:0]  req_s;      // Request synchroniser.
        logic [1:0]  bit_s;      // Command bit synchroniser.
        logic [1:0]  wg_s;       // Write gate synchroniser.
        logic [1:0]  ame_s;      // Address mark enable synchroniser.
        logic [1:0]  wc_s;       // Write clock synchroniser.
        logic [1:0]  wd_s;       // Write data synchroniser.
        logic [1:0]  am_s;       // Mark detector synchroniser.
        logic        req_d;      // Delayed synced request.
        logic        wg_d;
        logic        ame_d;
        logic        wc_d;
        dkhs_pkg::dkhs_state_t st;
        logic [4:0]  nbit;       // Bits in current transfer.
        logic [15:0] sh;         // Shift register.
        logic        resp;       // Status response in progress.
        logic        pe;         // Parity bit was bad.
        logic [ICW-1:0] icnt;    // Idle and handshake timer.
        logic [3:0]  lead;       // Attention lead counter.
        logic        ack;
        logic        cc;
        logic        at;
        logic        sbit;
        logic        amf;
        logic        sync;
        logic        wam;
        logic        cv;
        logic [15:0] cw;
        logic        cf;
        logic        xf;
        logic [7:0]  refc;       // Reference clock half-period counter.
        logic        rclk;
        logic [7:0]  wsh;        // Write data assembler.
        logic [2:0]  wcnt;
        logic        wpush;
    } dkhs_st_t;

    dkhs_st_t s_reg;             // Current state.
    dkhs_st_t s_next;            // Next state.
    logic     fifo_ready;        // FIFO can take a byte.

    // Odd parity check on a command word.
    function automatic logic par_ok(input logic [15:0] w, input logic p);
        return ^{w, p};
    endfunction

    // =====================================================================
    // Next state logic
    // =====================================================================
    always_comb begin
        logic req;
        logic rise;
        logic fall;
        req  = s_reg.req_s[1];
        rise = req && !s_reg.req_d;
        fall = !req && s_reg.req_d;
        s_next = s_reg;
        s_next.req_s = {s_reg.req_s[0], xfer_req};
        s_next.bit_s = {s_reg.bit_s[0], cmd_bit};
        s_next.wg_s  = {s_reg.wg_s[0], write_gate};
        s_next.ame_s = {s_reg.ame_s[0], am_enable};
        s_next.wc_s  = {s_reg.wc_s[0], write_clk};
        s_next.wd_s  = {s_reg.wd_s[0], write_data};
        s_next.am_s  = {s_reg.am_s[0], read_am_seen};
        s_next.req_d = req;
        s_next.wg_d  = s_reg.wg_s[1];
        s_next.ame_d = s_reg.ame_s[1];
        s_next.wc_d  = s_reg.wc_s[1];
        s_next.cv    = 1'b0;
        s_next.cf    = 1'b0;
        s_next.xf    = 1'b0;
        s_next.sync  = 1'b0;
        s_next.wpush = 1'b0;

        // Reference clock: fixed symmetrical halves, never a sliver.
        // Only whole half periods are produced, so no extended phase.
        if (s_reg.refc == 8'(REF_HALF - 1)) begin
            s_next.refc = '0;
            s_next.rclk = !s_reg.rclk;
        end else begin
            s_next.refc = s_reg.refc + 8'h01;
        end

        // Address mark found, two sync stages plus one: within 8 bit times.
        s_next.amf = s_reg.am_s[1];

        // Format: write gate rise starts sync field.
        // Mark enable fall starts sync with no mark written.
        if ((s_reg.wg_s[1] && !s_reg.wg_d) || (!s_reg.ame_s[1] && s_reg.ame_d)) begin
            s_next.sync = 1'b1;
        end
        s_next.wam = s_reg.ame_s[1] && s_reg.wg_s[1] && 1'b0;

        // Write data captured on the write clock leading edge, no phase
        // relation to the reference clock assumed.
        if (s_reg.wg_s[1] && s_reg.wc_s[1] && !s_reg.wc_d) begin
            s_next.wsh  = {s_reg.wsh[6:0], s_reg.wd_s[1]};
            s_next.wcnt = s_reg.wcnt + 3'h1;
            if (s_reg.wcnt == 3'h7) begin
                s_next.wpush = 1'b1;
            end
        end

        case (s_reg.st)
            dkhs_pkg::DKHS_IDLE: begin
                s_next.icnt = '0;
                if (rise) begin
                    // Drop command complete on request, with the ack.
                    s_next.cc   = 1'b0;
                    s_next.ack  = 1'b1;
                    s_next.sh   = status_req ? {status_word[14:0], 1'b0}
                                             : {s_reg.sh[14:0], s_reg.bit_s[1]};
                    s_next.sbit = status_word[15];
                    s_next.nbit = 5'h01;
                    s_next.st   = dkhs_pkg::DKHS_XFER;
                    s_next.resp = status_req;
                end
            end
            dkhs_pkg::DKHS_XFER: begin
                // Handshake limit of 10 ms per bit.
                s_next.icnt = s_reg.icnt + 1'b1;
                if (fall) begin
                    s_next.ack  = 1'b0;
                    s_next.icnt = '0;
                    if (s_reg.nbit == 5'h11) begin
                        s_next.cw = s_reg.sh;
                        if (s_reg.resp) begin
                            s_next.cc = 1'b1;   // Status transfer finished.
                            s_next.st = dkhs_pkg::DKHS_IDLE;
                        end else if (s_reg.pe) begin
                            // Error: attention, hold ack low, then idle wait.
                            s_next.at   = 1'b1;
                            s_next.cf   = 1'b1;
                            s_next.st   = dkhs_pkg::DKHS_ERRWAIT;
                        end else begin
                            s_next.cv = 1'b1;
                            s_next.st = dkhs_pkg::DKHS_EXEC;
                        end
                    end
                end else if (rise) begin
                    s_next.ack  = 1'b1;
                    s_next.icnt = '0;
                    // Bit 17 is parity; the word stays whole.
                    s_next.pe   = !par_ok(s_reg.sh, s_reg.bit_s[1]);
                    if (s_reg.nbit != 5'h10) begin
                        s_next.sh = s_reg.resp ? {s_reg.sh[14:0], 1'b0}
                                               : {s_reg.sh[14:0], s_reg.bit_s[1]};
                    end
                    s_next.sbit = s_reg.sh[15];
                    s_next.nbit = s_reg.nbit + 5'h01;
                end else if (s_reg.icnt == ICW'(IDLE_CYC)) begin
                    s_next.xf = 1'b1;
                    s_next.at = 1'b1;
                    s_next.ack = 1'b0;
                    s_next.st = dkhs_pkg::DKHS_ERRWAIT;
                end
            end
            dkhs_pkg::DKHS_EXEC: begin
                if (exec_done) begin
                    // Status bits 15..10 alone never raise attention.
                    if (exec_error || (|status_word[`DKHS_ATTN_BITS-1:0] && 1'b0)) begin
                        s_next.at   = 1'b1;
                        s_next.lead = '0;
                        s_next.st   = dkhs_pkg::DKHS_LEAD;
                    end else begin
                        s_next.cc = 1'b1;     // Execution finished.
                        s_next.st = dkhs_pkg::DKHS_IDLE;
                    end
                end
            end
            dkhs_pkg::DKHS_LEAD: begin
                // Attention stands six cycles, 120 ns, before command complete.
                s_next.lead = s_reg.lead + 4'h1;
                if (s_reg.lead == 4'(`DKHS_LEAD_CYC)) begin
                    s_next.cc = 1'b1;
                    s_next.st = dkhs_pkg::DKHS_IDLE;
                end
            end
            dkhs_pkg::DKHS_ERRWAIT: begin
                // Request must stay low 10 ms on the system clock.
                s_next.ack = 1'b0;
                if (req) begin
                    s_next.icnt = '0;
                    if (rise) begin
                        s_next.xf = 1'b1;   // Refuse as interface fault.
                    end
                end else if (s_reg.icnt == ICW'(IDLE_CYC)) begin
                    s_next.st = dkhs_pkg::DKHS_DONE;
                end else begin
                    s_next.icnt = s_reg.icnt + 1'b1;
                end
            end
            dkhs_pkg::DKHS_DONE: begin
                s_next.cc = 1'b1;
                s_next.st = dkhs_pkg::DKHS_IDLE;
            end
            default: begin
                s_next.st = dkhs_pkg::DKHS_IDLE;
            end
        endcase
        // Attention cleared only by a new non-status command start.
        if (s_reg.st == dkhs_pkg::DKHS_IDLE && rise && !status_req) begin
            s_next.at = 1'b0;
        end
    end

    // =====================================================================
    // Registers
    // =====================================================================
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_reg    <= '0;
            s_reg.st <= dkhs_pkg::DKHS_IDLE;
            s_reg.cc <= 1'b1;
        end else if (s_reg.wpush && !fifo_ready) begin
            // Back-pressure: keep the byte and its push pending while it cannot be taken; the rest advances.
            s_reg       <= s_next;
            s_reg.wpush <= 1'b1;
            s_reg.wsh   <= s_reg.wsh;
        end else begin
            s_reg <= s_next;
        end
    end

    // Write data buffer toward the formatter.
    dkhs_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .in_data  (s_reg.wsh),
        .in_valid (s_reg.wpush),
        .in_ready (fifo_ready),
        .out_data (wr_byte),
        .out_valid(wr_byte_valid),
        .out_ready(wr_byte_ready)
    );

    assign xfer_ack   = s_reg.ack;
    assign stat_bit   = s_reg.sbit;
    assign cmd_cmpl   = s_reg.cc;
    assign attn       = s_reg.at;
    assign am_found   = s_reg.amf;
    assign ref_clk    = s_reg.rclk;
    assign sync_start = s_reg.sync;
    assign write_am   = s_reg.wam;
    assign cmd_valid  = s_reg.cv;
    assign cmd_word   = s_reg.cw;
    assign cmd_fault  = s_reg.cf;
    assign xfer_fault = s_reg.xf;
endmodule // dkhs_core

/* dkhs_core_sva.sv */
`timescale 1ns/1ps
// ==========
// Port checker for the drive handshake core.
module dkhs_core_sva #(
    parameter int IDLE_CYC = 50,
    parameter int REF_HALF = 2
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic xfer_req,
    input wire logic xfer_ack,
    input wire logic cmd_cmpl,
    input wire logic attn,
    input wire logic read_am_seen,
    input wire logic am_found,
    input wire logic ref_clk,
    input wire logic write_gate,
    input wire logic am_enable,
    input wire logic sync_start,
    input wire logic write_am,
    input wire logic cmd_fault,
    input wire logic xfer_fault,
    input wire logic exec_done
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic        err_wait_reg; // Parity fault seen, complete not yet given.
    logic [15:0] idle_cnt_reg; // Raw request-idle cycles; saturates.
    logic [6:0]  low_cnt_reg;  // Length of the current low clock phase.
    // Counting on the raw request keeps the bound a lower one: sync lag only adds.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            err_wait_reg <= 1'b0;
            idle_cnt_reg <= 16'h0000;
            low_cnt_reg  <= 7'h00;
        end else begin
            err_wait_reg <= cmd_fault ? 1'b1 : (cmd_cmpl ? 1'b0 : err_wait_reg);
            idle_cnt_reg <= xfer_req ? 16'h0000 : idle_cnt_reg + {15'h0000, ~&idle_cnt_reg};
            low_cnt_reg  <= ref_clk ? 7'h00 : low_cnt_reg + {6'h00, ~&low_cnt_reg};
        end
    end
    sequence s_ref_high;
        ref_clk [*4] ##1 !ref_clk;
    endsequence
    sequence s_err_hold;
        (attn && !xfer_ack && !cmd_cmpl) [*8];
    endsequence
    a_cmpl_drop: assert property ($rose(xfer_ack) |-> !cmd_cmpl)
        else $error("Complete still high when ack rose.");
    a_exec_cmpl: assert property ($rose(exec_done) |-> ##[1:10] cmd_cmpl)
        else $error("Complete late after execution.");
    a_attn_lead: assert property ($rose(cmd_cmpl) && attn |-> $past(attn, 5))
        else $error("Attention did not lead complete.");
    a_mark_found: assert property ($rose(read_am_seen) |-> ##[1:32] am_found)
        else $error("Mark found late.");
    a_gate_sync: assert property ($rose(write_gate) |-> ##[1:5] sync_start)
        else $error("No sync start on write gate.");
    a_enable_sync: assert property ($fell(am_enable) |-> ##[1:5] sync_start)
        else $error("No sync start on enable fall.");
    a_no_mark: assert property (!write_am)
        else $error("Mark written.");
    a_ref_high: assert property ($rose(ref_clk) |-> s_ref_high)
        else $error("High phase not nominal.");
    a_ref_low: assert property ($fell(ref_clk) |-> !ref_clk [*4])
        else $error("Low phase sliver.");
    a_ref_stretch: assert property (low_cnt_reg <= 7'h74)
        else $error("Clock period stretched too far.");
    a_err_hold: assert property ($rose(err_wait_reg) |-> ##[0:4] s_err_hold)
        else $error("Error wait levels wrong.");
    a_err_idle: assert property (err_wait_reg && $rose(cmd_cmpl) |-> idle_cnt_reg >= IDLE_CYC)
        else $error("Complete before idle span.");
    a_early_fault: assert property (err_wait_reg && $rose(xfer_req) |-> ##[1:6] xfer_fault)
        else $error("Early request not refused.");
endmodule // dkhs_core_sva

/* dkhs_ctrl_model.sv */
`timescale 1ns/1ps
// ==========
// Controller model: serial command sender and write stream source.
module dkhs_ctrl_model (
    input  wire logic sys_clk,
    input  wire logic xfer_ack,
    output logic      xfer_req,
    output logic      cmd_bit,
    output logic      write_clk,
    output logic      write_data
);
    int late_cnt; // Handshakes that overran the wait bound.
    initial begin
        {xfer_req, cmd_bit, write_clk, write_data} = 4'h0;
        late_cnt = 0;
    end
    // Bounded wait for an ack level, looked at once edge updates have landed.
    task automatic wait_ack(input logic lvl);
        int n;
        n = 0;
        while (xfer_ack !== lvl && n < 1000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 1000) late_cnt++;
    endtask
    // Request held with its bit until ack is seen; the line then shows the inverse.
    task automatic send_bit(input logic b);
        @(posedge sys_clk);
        #1;
        cmd_bit  = b;
        xfer_req = 1'b1;
        wait_ack(1'b1);
        xfer_req = 1'b0;
        cmd_bit  = ~b;
        wait_ack(1'b0);
    endtask
    // Sixteen bits MSB first, then odd parity; bad flips the parity bit.
    task automatic send_cmd(input logic [15:0] w, input logic bad);
        for (int i = 15; i >= 0; i--) send_bit(w[i]);
        send_bit(~(^w) ^ bad);
    endtask
    // Stray request pulse, used to break the idle wait on purpose.
    task automatic req_pulse();
        @(posedge sys_clk);
        #1 xfer_req = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 xfer_req = 1'b0;
    endtask
    // Data moves while the clock is low so it is steady at the rise; clock idles low.
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            write_data = b[i];
            #80 write_clk = 1'b1;
            #80 write_clk = 1'b0;
        end
        write_data = ~b[0];
    endtask
endmodule // dkhs_ctrl_model

/* disk_drive_handshake_timing_bench.sv */
`timescale 1ns/1ps
// ==========
// Self-checking bench for the drive handshake core.
module disk_drive_handshake_timing_bench;
    localparam int IDLE = 50; // Short idle span keeps the run brief.
    logic        sys_clk, rst_n, xfer_req, cmd_bit, xfer_ack, stat_bit, cmd_cmpl, attn;
    logic        write_gate, am_enable, write_clk, write_data, read_am_seen, am_found;
    logic        ref_clk, sync_start, write_am, cmd_valid, cmd_fault, exec_done;
    logic        exec_error, status_req, wr_byte_valid, wr_byte_ready, xfer_fault;
    logic        fault_seen, xfault_seen, valid_seen, sync_seen;
    logic [15:0] cmd_word, status_word, word_seen;
    logic [7:0]  wr_byte;
    int          err_count, samples_checked;
    always #10 sys_clk = ~sys_clk;
    dkhs_core #(.IDLE_CYC(IDLE), .REF_HALF(4), .FIFO_DEPTH(16)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .xfer_req(xfer_req), .cmd_bit(cmd_bit),
        .xfer_ack(xfer_ack), .stat_bit(stat_bit), .cmd_cmpl(cmd_cmpl), .attn(attn),
        .write_gate(write_gate), .am_enable(am_enable), .write_clk(write_clk),
        .write_data(write_data), .read_am_seen(read_am_seen), .am_found(am_found),
        .ref_clk(ref_clk), .sync_start(sync_start), .write_am(write_am),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_fault(cmd_fault),
        .exec_done(exec_done), .exec_error(exec_error), .status_req(status_req),
        .status_word(status_word), .wr_byte(wr_byte), .wr_byte_valid(wr_byte_valid),
        .wr_byte_ready(wr_byte_ready), .xfer_fault(xfer_fault));
    dkhs_ctrl_model u_ctrl (.sys_clk(sys_clk), .xfer_ack(xfer_ack), .xfer_req(xfer_req),
        .cmd_bit(cmd_bit), .write_clk(write_clk), .write_data(write_data));
    // One-cycle pulses are caught here so tasks may look later.
    always @(posedge sys_clk) begin
        if (cmd_fault === 1'b1) fault_seen <= 1'b1;
        if (xfer_fault === 1'b1) xfault_seen <= 1'b1;
        if (sync_start === 1'b1) sync_seen <= 1'b1;
        if (cmd_valid === 1'b1) begin
            valid_seen <= 1'b1;
            word_seen  <= cmd_word;
        end
    end
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic chk1(input string name, input logic seen, input logic exp);
        chk(name, {15'h0000, seen}, {15'h0000, exp});
    endtask
    task automatic step(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Reference clock phases: nominal high, low never a sliver nor overlong.
    task automatic t_ref();
        int hi, lo, n;
        {hi, lo, n} = {32'd0, 32'd0, 32'd0};
        while (ref_clk !== 1'b0 && n < 50) begin step(1); n++; end
        while (ref_clk !== 1'b1 && n < 100) begin step(1); n++; end
        while (ref_clk === 1'b1 && hi < 50) begin step(1); hi++; end
        while (ref_clk === 1'b0 && lo < 150) begin step(1); lo++; end
        chk("ref_high", 16'(hi), 16'h0004);
        chk1("ref_low_ok", lo >= 4 && lo <= 116, 1'b1);
    endtask
    // Clean command, then execution end raises complete without attention.
    task automatic t_good(input logic [15:0] w);
        int n;
        n = 0;
        valid_seen = 1'b0;
        chk1("cmpl_idle", cmd_cmpl, 1'b1);
        u_ctrl.send_cmd(w, 1'b0);
        while (valid_seen !== 1'b1 && n < 20) begin step(1); n++; end
        chk("cmd_word", word_seen, w);
        chk1("cmpl_low", cmd_cmpl, 1'b0);
        chk("late", 16'(u_ctrl.late_cnt), 16'h0000);
        exec_done = 1'b1;
        step(1);
        exec_done = 1'b0;
        n = 0;
        while (cmd_cmpl !== 1'b1 && n < 20) begin step(1); n++; end
        chk1("cmpl_high", cmd_cmpl, 1'b1);
        chk1("attn_low", attn, 1'b0);
    endtask
    // Execution error: attention must lead complete by five cycles.
    task automatic t_exec_err();
        int n, ta;
        {n, ta} = {32'd0, -32'sd1};
        u_ctrl.send_cmd(16'h1234, 1'b0);
        step(8);
        {exec_error, exec_done} = 2'b11;
        step(1);
        {exec_error, exec_done} = 2'b00;
        while (cmd_cmpl !== 1'b1 && n < 40) begin
            if (attn === 1'b1 && ta < 0) ta = n;
            step(1);
            n++;
        end
        chk1("attn_lead", ta >= 0 && n - ta >= 5 && n < 40, 1'b1);
    endtask
    // Parity fault: hold levels, refuse a stray request, complete after the idle span.
    task automatic t_par_err();
        int n;
        {fault_seen, xfault_seen} = 2'b00;
        u_ctrl.send_cmd(16'h5A0F, 1'b1);
        step(10);
        chk1("parity_fault", fault_seen, 1'b1);
        chk1("attn_hold", attn, 1'b1);
        chk1("ack_low", xfer_ack, 1'b0);
        u_ctrl.req_pulse();
        step(8);
        chk1("early_fault", xfault_seen, 1'b1);
        chk1("cmpl_wait", cmd_cmpl, 1'b0);
        n = 8;
        while (cmd_cmpl !== 1'b1 && n < 300) begin step(1); n++; end
        chk1("idle_span", n >= IDLE && n < 300, 1'b1);
        status_req = 1'b1;
        u_ctrl.send_cmd(16'h0000, 1'b0);
        chk1("stat_done", cmd_cmpl & attn, 1'b1);
        status_req = 1'b0;
    endtask
    // Mark found, enable fall, then a gated write frame into a stalled buffer.
    task automatic t_format();
        int n;
        n = 0;
        read_am_seen = 1'b1;
        while (am_found !== 1'b1 && n < 40) begin step(1); n++; end
        chk1("mark_found", n <= 32, 1'b1);
        {read_am_seen, am_enable, sync_seen} = 3'b010;
        step(10);
        chk1("no_mark", write_am, 1'b0);
        am_enable = 1'b0;
        step(8);
        chk1("enable_sync", sync_seen, 1'b1);
        {sync_seen, write_gate} = 2'b01;
        step(8);
        chk1("gate_sync", sync_seen, 1'b1);
        for (int k = 0; k < 16; k++) u_ctrl.send_byte(8'(k * 29 + 5));
        step(4);
        write_gate = 1'b0;
        for (int k = 0; k < 16; k++) begin
            n = 0;
            while (wr_byte_valid !== 1'b1 && n < 40) begin step(1); n++; end
            chk("wr_byte", {8'h00, wr_byte}, {8'h00, 8'(k * 29 + 5)});
            wr_byte_ready = 1'b1;
            step(1);
            wr_byte_ready = 1'b0;
        end
        step(2);
        chk1("fifo_empty", wr_byte_valid, 1'b0);
    endtask
    initial begin
        {sys_clk, rst_n, exec_done, exec_error, status_req} = 5'h00;
        {write_gate, am_enable, read_am_seen, wr_byte_ready} = 4'h0;
        {fault_seen, xfault_seen, valid_seen, sync_seen} = 4'h0;
        {status_word, word_seen} = {16'hFC00, 16'h0000};
        {err_count, samples_checked} = {32'd0, 32'd0};
        step(2);
        rst_n = 1'b1;
        step(3);
        t_ref();
        t_good(16'hA5C3);
        t_exec_err();
        t_par_err();
        t_good(16'hFFFF);
        t_format();
        print_verdict();
    end
    // Hang guard, well past the few tens of microseconds the tests need.
    initial begin
        #400000;
        err_count++;
        print_verdict();
    end
endmodule // disk_drive_handshake_timing_bench
bind dkhs_core dkhs_core_sva #(.IDLE_CYC(IDLE_CYC), .REF_HALF(REF_HALF)) u_sva (
    .sys_clk(sys_clk), .rst_n(rst_n), .xfer_req(xfer_req), .xfer_ack(xfer_ack),
    .cmd_cmpl(cmd_cmpl), .attn(attn), .read_am_seen(read_am_seen), .am_found(am_found),
    .ref_clk(ref_clk), .write_gate(write_gate), .am_enable(am_enable),
    .sync_start(sync_start), .write_am(write_am), .cmd_fault(cmd_fault),
    .xfer_fault(xfer_fault), .exec_done(exec_done));
